/* File: pkg/bus_xcvr_pkg.sv */
// Package: register map, control layout and reset values of the bus transceiver
package bus_xcvr_pkg;

  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam logic [31:0] CTRL_OFF    = 32'h0000_0000;
  localparam logic [31:0] STORE_A_OFF = 32'h0000_0004;
  localparam logic [31:0] STORE_B_OFF = 32'h0000_0008;
  localparam logic [31:0] PINS_OFF    = 32'h0000_000c;
  localparam logic [31:0] DRIVE_OFF   = 32'h0000_0010;

  // ****************************************
  // Field layout
  // ****************************************
  localparam int CTRL_FIELD_W   = 4;
  localparam int DRIVE_FIELD_W  = 2;
  localparam int STORE_A_POS    = 0;

  // ****************************************
  // Bus answers
  // ****************************************
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Per-section controls
  typedef struct packed {
    logic port_en_n;
    logic dir;
    logic a_to_b_source_sel;
    logic b_to_a_source_sel;
  } section_ctrl_type;

  // Isolated after reset: neither port is driven
  localparam section_ctrl_type CTRL_RESET = '{port_en_n: 1'b1, dir: 1'b0,
                                              a_to_b_source_sel: 1'b0, b_to_a_source_sel: 1'b0};

  // Decoded register selector
  typedef enum logic [2:0] {
    SEL_CTRL    = 3'h0,
    SEL_STORE_A = 3'h1,
    SEL_STORE_B = 3'h2,
    SEL_PINS    = 3'h3,
    SEL_DRIVE   = 3'h4,
    SEL_NONE    = 3'h7
  } reg_sel_type;

  // AXI4-Lite write request carrier: address, data and strobes
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] data;
    logic [3:0]  strb;
  } wr_req_type;

endpackage

/* File: core/bus_transceiver.sv */
// Module: registered two-section bus transceiver with AXI4-Lite control
`timescale 1ns/1ps

// Function
// - Two identical independently controlled 8-bit sections
// - Capture clock rising edge loads its port
// - Capture never gated by enable or direction
// - Enable high: neither port driven, captures continue
// - No capture edge: stored contents held
// - Direction low drives A, high drives B
// - A driven, select low: live B passes
// - A driven, select high: stored B drives
// - B driven, select low: live A passes
// - B driven, select high: stored A drives
// - Undriven port remains capturable while other driven
// - Source change moves cleanly, no glitch
// - Disabled output keeps input and storage working
module bus_transceiver #(
  parameter int SECTIONS  = 2,
  parameter int SECTION_W = 8
) (
  input  wire logic                            mclk,
  input  wire logic                            sys_rst,
  input  wire logic [31:0]                     awaddr,
  input  wire logic                            awvalid,
  output logic                                 awready,
  input  wire logic [31:0]                     wdata,
  input  wire logic [3:0]                      wstrb,
  input  wire logic                            wvalid,
  output logic                                 wready,
  output logic [1:0]                           bresp,
  output logic                                 bvalid,
  input  wire logic                            bready,
  input  wire logic [31:0]                     araddr,
  input  wire logic                            arvalid,
  output logic                                 arready,
  output logic [31:0]                          rdata,
  output logic [1:0]                           rresp,
  output logic                                 rvalid,
  input  wire logic                            rready,
  input  wire logic [SECTIONS-1:0]             a_side_capture_clk,
  input  wire logic [SECTIONS-1:0]             b_side_capture_clk,
  input  wire logic [SECTIONS*SECTION_W-1:0]   a_in,
  output logic      [SECTIONS*SECTION_W-1:0]   a_out,
  output logic      [SECTIONS-1:0]             a_oe_n,
  input  wire logic [SECTIONS*SECTION_W-1:0]   b_in,
  output logic      [SECTIONS*SECTION_W-1:0]   b_out,
  output logic      [SECTIONS-1:0]             b_oe_n
);

  localparam int WIDTH = SECTIONS * SECTION_W;

  // ****************************************
  // Elaboration checks
  // ****************************************
  // Live pins of both ports share one 32-bit word
  if (WIDTH > 16 || SECTIONS < 1 || SECTION_W < 1 ||
      SECTIONS * bus_xcvr_pkg::CTRL_FIELD_W > 8) begin : g_bad_size
    $error("bus_transceiver: sections or width out of range");
  end

  // ****************************************
  // Helpers
  // ****************************************
  function automatic bus_xcvr_pkg::reg_sel_type decode(input logic [31:0] addr);
    case (addr)
      bus_xcvr_pkg::CTRL_OFF:    decode = bus_xcvr_pkg::SEL_CTRL;
      bus_xcvr_pkg::STORE_A_OFF: decode = bus_xcvr_pkg::SEL_STORE_A;
      bus_xcvr_pkg::STORE_B_OFF: decode = bus_xcvr_pkg::SEL_STORE_B;
      bus_xcvr_pkg::PINS_OFF:    decode = bus_xcvr_pkg::SEL_PINS;
      bus_xcvr_pkg::DRIVE_OFF:   decode = bus_xcvr_pkg::SEL_DRIVE;
      default:                   decode = bus_xcvr_pkg::SEL_NONE;
    endcase
  endfunction

  // ****************************************
  // State
  // ****************************************
  bus_xcvr_pkg::section_ctrl_type [SECTIONS-1:0] ctrl_r, ctrl_nxt;
  logic [WIDTH-1:0]    a_store_r, a_store_nxt;
  logic [WIDTH-1:0]    b_store_r, b_store_nxt;
  logic [SECTIONS-1:0] a_clk_prev_r, a_clk_prev_nxt;
  logic [SECTIONS-1:0] b_clk_prev_r, b_clk_prev_nxt;
  logic [WIDTH-1:0]    a_out_r, a_out_nxt, b_out_r, b_out_nxt;
  logic [SECTIONS-1:0] a_oe_n_r, a_oe_n_nxt, b_oe_n_r, b_oe_n_nxt;

  bus_xcvr_pkg::wr_req_type wr_r, wr_nxt;
  logic        aw_held_r, aw_held_nxt, w_held_r, w_held_nxt;
  logic        awready_r, awready_nxt, wready_r, wready_nxt;
  logic        bvalid_r, bvalid_nxt;
  logic [1:0]  bresp_r, bresp_nxt;
  logic        arready_r, arready_nxt, rvalid_r, rvalid_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [1:0]  rresp_r, rresp_nxt;

  // ****************************************
  // Capture path
  // ****************************************
  // Capture clocks are sampled pins; an edge is a low-to-high step between samples
  always_comb begin
    a_store_nxt  = a_store_r;
    b_store_nxt  = b_store_r;
    a_clk_prev_nxt = a_side_capture_clk;
    b_clk_prev_nxt = b_side_capture_clk;
    for (int s = 0; s < SECTIONS; s++) begin
      if (a_side_capture_clk[s] && !a_clk_prev_r[s]) begin
        a_store_nxt[s*SECTION_W +: SECTION_W] = a_in[s*SECTION_W +: SECTION_W];
      end
      if (b_side_capture_clk[s] && !b_clk_prev_r[s]) begin
        b_store_nxt[s*SECTION_W +: SECTION_W] = b_in[s*SECTION_W +: SECTION_W];
      end
    end
  end

  // Stored data carries no reset on purpose
  always_ff @(posedge mclk) begin
    a_store_r <= a_store_nxt;
    b_store_r <= b_store_nxt;
  end

  // Held high in reset so a clock already high does not fake an edge
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      a_clk_prev_r <= '1;
      b_clk_prev_r <= '1;
    end else begin
      a_clk_prev_r <= a_clk_prev_nxt;
      b_clk_prev_r <= b_clk_prev_nxt;
    end
  end

  // ****************************************
  // Drive path
  // ****************************************
  // Registered mux: output steps straight from old to new source
  always_comb begin
    a_out_nxt  = '0;
    b_out_nxt  = '0;
    a_oe_n_nxt = '1;
    b_oe_n_nxt = '1;
    for (int s = 0; s < SECTIONS; s++) begin
      if (!ctrl_r[s].port_en_n) begin
        if (!ctrl_r[s].dir) begin
          a_oe_n_nxt[s] = 1'b0;
          if (ctrl_r[s].b_to_a_source_sel) begin
            a_out_nxt[s*SECTION_W +: SECTION_W] = b_store_r[s*SECTION_W +: SECTION_W];
          end else begin
            a_out_nxt[s*SECTION_W +: SECTION_W] = b_in[s*SECTION_W +: SECTION_W];
          end
        end else begin
          b_oe_n_nxt[s] = 1'b0;
          if (ctrl_r[s].a_to_b_source_sel) begin
            b_out_nxt[s*SECTION_W +: SECTION_W] = a_store_r[s*SECTION_W +: SECTION_W];
          end else begin
            b_out_nxt[s*SECTION_W +: SECTION_W] = a_in[s*SECTION_W +: SECTION_W];
          end
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      a_out_r  <= '0;
      b_out_r  <= '0;
      a_oe_n_r <= '1;
      b_oe_n_r <= '1;
    end else begin
      a_out_r  <= a_out_nxt;
      b_out_r  <= b_out_nxt;
      a_oe_n_r <= a_oe_n_nxt;
      b_oe_n_r <= b_oe_n_nxt;
    end
  end

  // ****************************************
  // Register write channel
  // ****************************************
  always_comb begin
    wr_nxt      = wr_r;
    aw_held_nxt = aw_held_r;
    w_held_nxt  = w_held_r;
    bvalid_nxt  = bvalid_r;
    bresp_nxt   = bresp_r;
    ctrl_nxt    = ctrl_r;
    if (bvalid_r && bready) begin
      bvalid_nxt = 1'b0;
    end
    if (awvalid && awready_r) begin
      aw_held_nxt = 1'b1;
      wr_nxt.addr = awaddr;
    end
    if (wvalid && wready_r) begin
      w_held_nxt  = 1'b1;
      wr_nxt.data = wdata;
      wr_nxt.strb = wstrb;
    end
    if (aw_held_nxt && w_held_nxt && !bvalid_r) begin
      aw_held_nxt = 1'b0;
      w_held_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = bus_xcvr_pkg::RESP_OKAY;
      case (decode(wr_nxt.addr))
        bus_xcvr_pkg::SEL_CTRL: begin
          // Only byte 0 holds controls
          if (wr_nxt.strb[0]) begin
            ctrl_nxt = wr_nxt.data[SECTIONS*bus_xcvr_pkg::CTRL_FIELD_W-1:0];
          end
        end
        bus_xcvr_pkg::SEL_STORE_A, bus_xcvr_pkg::SEL_STORE_B,
        bus_xcvr_pkg::SEL_PINS, bus_xcvr_pkg::SEL_DRIVE: begin
          bresp_nxt = bus_xcvr_pkg::RESP_OKAY;
        end
        default: begin
          bresp_nxt = bus_xcvr_pkg::RESP_SLVERR;
        end
      endcase
    end
    awready_nxt = !aw_held_nxt && !bvalid_nxt;
    wready_nxt  = !w_held_nxt && !bvalid_nxt;
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      wr_r      <= '0;
      aw_held_r <= 1'b0;
      w_held_r  <= 1'b0;
      awready_r <= 1'b1;
      wready_r  <= 1'b1;
      bvalid_r  <= 1'b0;
      bresp_r   <= bus_xcvr_pkg::RESP_OKAY;
      ctrl_r    <= {SECTIONS{bus_xcvr_pkg::CTRL_RESET}};
    end else begin
      wr_r      <= wr_nxt;
      aw_held_r <= aw_held_nxt;
      w_held_r  <= w_held_nxt;
      awready_r <= awready_nxt;
      wready_r  <= wready_nxt;
      bvalid_r  <= bvalid_nxt;
      bresp_r   <= bresp_nxt;
      ctrl_r    <= ctrl_nxt;
    end
  end

  // ****************************************
  // Register read channel
  // ****************************************
  always_comb begin
    rvalid_nxt = rvalid_r;
    rdata_nxt  = rdata_r;
    rresp_nxt  = rresp_r;
    if (rvalid_r && rready) begin
      rvalid_nxt = 1'b0;
    end
    if (arvalid && arready_r) begin
      rvalid_nxt = 1'b1;
      rdata_nxt  = '0;
      rresp_nxt  = bus_xcvr_pkg::RESP_OKAY;
      case (decode(araddr))
        bus_xcvr_pkg::SEL_CTRL:    rdata_nxt = 32'(ctrl_r);
        bus_xcvr_pkg::SEL_STORE_A: rdata_nxt = 32'(a_store_r);
        bus_xcvr_pkg::SEL_STORE_B: rdata_nxt = 32'(b_store_r);
        bus_xcvr_pkg::SEL_PINS:    rdata_nxt = 32'({b_in, a_in});
        bus_xcvr_pkg::SEL_DRIVE:   rdata_nxt = 32'({b_oe_n_r, a_oe_n_r});
        default:                   rresp_nxt = bus_xcvr_pkg::RESP_SLVERR;
      endcase
    end
    arready_nxt = !rvalid_nxt;
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
      rdata_r   <= '0;
      rresp_r   <= bus_xcvr_pkg::RESP_OKAY;
    end else begin
      arready_r <= arready_nxt;
      rvalid_r  <= rvalid_nxt;
      rdata_r   <= rdata_nxt;
      rresp_r   <= rresp_nxt;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign awready = awready_r;
  assign wready  = wready_r;
  assign bvalid  = bvalid_r;
  assign bresp   = bresp_r;
  assign arready = arready_r;
  assign rvalid  = rvalid_r;
  assign rdata   = rdata_r;
  assign rresp   = rresp_r;
  assign a_out   = a_out_r;
  assign a_oe_n  = a_oe_n_r;
  assign b_out   = b_out_r;
  assign b_oe_n  = b_oe_n_r;

endmodule

/* File: sim/bus_xcvr_properties.sv */
// Checker of the bus transceiver ports
`timescale 1ns/1ps
module bus_xcvr_properties #(
  parameter int SECTIONS  = 2,
  parameter int SECTION_W = 8
) (
  input wire logic                          mclk,
  input wire logic                          sys_rst,
  input wire logic                          awvalid,
  input wire logic                          awready,
  input wire logic                          wvalid,
  input wire logic                          wready,
  input wire logic [1:0]                    bresp,
  input wire logic                          bvalid,
  input wire logic                          bready,
  input wire logic                          arvalid,
  input wire logic                          arready,
  input wire logic [31:0]                   rdata,
  input wire logic                          rvalid,
  input wire logic                          rready,
  input wire logic [SECTIONS*SECTION_W-1:0] a_out,
  input wire logic [SECTIONS-1:0]           a_oe_n,
  input wire logic [SECTIONS*SECTION_W-1:0] b_out,
  input wire logic [SECTIONS-1:0]           b_oe_n
);
  // ****************************************
  // Port and bus properties
  // ****************************************
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  property p_one_port; (a_oe_n | b_oe_n) == '1; endproperty
  a_one_port: assert property (p_one_port) else $error("both ports driven");
  property p_idle_zero; (&a_oe_n && &b_oe_n) |-> (a_out == '0 && b_out == '0); endproperty
  a_idle_zero: assert property (p_idle_zero) else $error("isolated output not zero");
  property p_rst; disable iff (1'b0) sys_rst |=> (&a_oe_n && &b_oe_n && !bvalid && !rvalid); endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  property p_b_hold; bvalid && !bready |=> bvalid && $stable(bresp); endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  property p_r_hold; rvalid && !rready |=> rvalid && $stable(rdata); endproperty
  a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
  property p_b_answer; awvalid && awready && wvalid && wready |=> bvalid && !awready && !wready; endproperty
  a_b_answer: assert property (p_b_answer) else $error("no write answer");
  property p_r_answer; arvalid && arready |=> rvalid && !arready; endproperty
  a_r_answer: assert property (p_r_answer) else $error("no read answer");
  // Drive changes only follow a control write
  property p_oe_cause; (a_oe_n != $past(a_oe_n) || b_oe_n != $past(b_oe_n)) |-> $past(bvalid); endproperty
  a_oe_cause: assert property (p_oe_cause) else $error("drive changed without write");
  c_drive_b: cover property (!b_oe_n[0]);
  c_drive_a: cover property (!a_oe_n[1]);
  c_write: cover property (bvalid && bready);
endmodule

bind bus_transceiver bus_xcvr_properties #(.SECTIONS(SECTIONS), .SECTION_W(SECTION_W)) u_props (.mclk, .sys_rst,
  .awvalid, .awready, .wvalid, .wready, .bresp, .bvalid, .bready, .arvalid, .arready, .rdata, .rvalid, .rready,
  .a_out, .a_oe_n, .b_out, .b_oe_n);

/* File: sim/bus_far_side.sv */
// Far-side model: external drivers of both ports
`timescale 1ns/1ps
module bus_far_side (
  input  wire logic [1:0]  a_oe_n,
  input  wire logic [15:0] a_out,
  input  wire logic [15:0] a_drv,
  output logic      [15:0] a_pin,
  input  wire logic [1:0]  b_oe_n,
  input  wire logic [15:0] b_out,
  input  wire logic [15:0] b_drv,
  output logic      [15:0] b_pin
);
  // Outside logic lets go of any section the device drives
  always_comb begin
    for (int s = 0; s < 2; s++) begin
      a_pin[8*s +: 8] = a_oe_n[s] ? a_drv[8*s +: 8] : a_out[8*s +: 8];
      b_pin[8*s +: 8] = b_oe_n[s] ? b_drv[8*s +: 8] : b_out[8*s +: 8];
    end
  end
endmodule

/* File: sim/tb_registered_bus_transceiver.sv */
// Testbench of the bus transceiver
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_errors++; $display("MISMATCH %0t %h %h", $time, g, e); end end
module tb_registered_bus_transceiver;
  logic        mclk, sys_rst, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [31:0] awaddr, wdata, araddr, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, a_side_capture_clk, b_side_capture_clk, a_oe_n, b_oe_n;
  logic [15:0] a_out, b_out, a_drv, b_drv, a_pin, b_pin;
  int          n_errors, comparisons;

  bus_transceiver dut (.mclk, .sys_rst, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
    .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .a_side_capture_clk,
    .b_side_capture_clk, .a_in(a_pin), .a_out, .a_oe_n, .b_in(b_pin), .b_out, .b_oe_n);
  bus_far_side far (.a_oe_n, .a_out, .a_drv, .a_pin, .b_oe_n, .b_out, .b_drv, .b_pin);

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  // ****************************************
  // Bus and capture tasks
  // ****************************************
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic hang(input int i);
    if (i >= 50) begin
      n_errors++;
      $display("MISMATCH %0t no answer", $time);
      test_done;
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
    int i;
    @(posedge mclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge mclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    hang(i);
    `CHK(bresp, er)
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] ed, input logic [1:0] er);
    int i;
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge mclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    hang(i);
    `CHK(rdata, ed)
    `CHK(rresp, er)
  endtask
  // Clock held high two cycles, low three: meets the minimum width
  task automatic cap(input logic [1:0] am, input logic [1:0] bm);
    @(posedge mclk);
    a_side_capture_clk <= am;
    b_side_capture_clk <= bm;
    repeat (2) @(posedge mclk);
    a_side_capture_clk <= 2'b00;
    b_side_capture_clk <= 2'b00;
    repeat (3) @(posedge mclk);
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset;
    rd(bus_xcvr_pkg::CTRL_OFF, 32'h0000_0088, bus_xcvr_pkg::RESP_OKAY);
    rd(bus_xcvr_pkg::DRIVE_OFF, 32'h0000_000f, bus_xcvr_pkg::RESP_OKAY);
    rd(32'h0000_0014, 32'h0000_0000, bus_xcvr_pkg::RESP_SLVERR);
    wr(32'h0000_0014, 32'h0000_0000, bus_xcvr_pkg::RESP_SLVERR);
    // Control write without byte 0 strobe is ignored
    wstrb <= 4'he;
    wr(bus_xcvr_pkg::CTRL_OFF, 32'h0000_0000, bus_xcvr_pkg::RESP_OKAY);
    wstrb <= 4'hf;
    rd(bus_xcvr_pkg::CTRL_OFF, 32'h0000_0088, bus_xcvr_pkg::RESP_OKAY);
    $display("reset test done");
  endtask
  task automatic t_isolate;
    a_drv <= 16'h5aa5;
    b_drv <= 16'h3cc3;
    cap(2'b11, 2'b11);
    rd(bus_xcvr_pkg::STORE_A_OFF, 32'h0000_5aa5, bus_xcvr_pkg::RESP_OKAY);
    rd(bus_xcvr_pkg::STORE_B_OFF, 32'h0000_3cc3, bus_xcvr_pkg::RESP_OKAY);
    a_drv <= 16'h1234;
    cap(2'b10, 2'b00);
    wr(bus_xcvr_pkg::STORE_A_OFF, 32'h0000_0000, bus_xcvr_pkg::RESP_OKAY);
    rd(bus_xcvr_pkg::STORE_A_OFF, 32'h0000_12a5, bus_xcvr_pkg::RESP_OKAY);
    rd(bus_xcvr_pkg::PINS_OFF, 32'h3cc3_1234, bus_xcvr_pkg::RESP_OKAY);
    `CHK({a_oe_n, b_oe_n, a_out, b_out}, 36'hf_0000_0000)
    $display("isolation test done");
  endtask
  task automatic t_live;
    wr(bus_xcvr_pkg::CTRL_OFF, 32'h0000_0004, bus_xcvr_pkg::RESP_OKAY);
    repeat (3) @(posedge mclk);
    `CHK({a_oe_n, b_oe_n}, 4'h6)
    `CHK({a_pin[15:8], b_pin[7:0]}, 16'h3c34)
    a_drv <= 16'h12c7;
    b_drv <= 16'h9ec3;
    repeat (3) @(posedge mclk);
    `CHK({a_pin[15:8], b_pin[7:0]}, 16'h9ec7)
    $display("live test done");
  endtask
  task automatic t_stored;
    b_drv <= 16'h3cc3;
    wr(bus_xcvr_pkg::CTRL_OFF, 32'h0000_0016, bus_xcvr_pkg::RESP_OKAY);
    repeat (3) @(posedge mclk);
    `CHK({a_pin[15:8], b_pin[7:0]}, 16'h3ca5)
    a_drv <= 16'h1266;
    b_drv <= 16'h77c3;
    cap(2'b01, 2'b10);
    `CHK({a_pin[15:8], b_pin[7:0]}, 16'h7766)
    cap(2'b10, 2'b00);
    rd(bus_xcvr_pkg::STORE_A_OFF, 32'h0000_7766, bus_xcvr_pkg::RESP_OKAY);
    wr(bus_xcvr_pkg::CTRL_OFF, 32'h0000_0088, bus_xcvr_pkg::RESP_OKAY);
    repeat (3) @(posedge mclk);
    `CHK({a_oe_n, b_oe_n}, 4'hf)
    $display("stored test done");
  endtask

  initial begin
    {sys_rst, awvalid, wvalid, bready, arvalid, rready} = 6'h20;
    {awaddr, wdata, araddr, a_drv, b_drv} = '0;
    wstrb = 4'hf;
    a_side_capture_clk = 2'b00;
    b_side_capture_clk = 2'b00;
    repeat (8) @(posedge mclk);
    sys_rst <= 1'b0;
    t_reset;
    t_isolate;
    t_live;
    t_stored;
    test_done;
  end
endmodule
